//--- rtl/mifd_decoder.v
// instruction field decoder with its software registers
`timescale 1ns/1ps
`default_nettype none
`include "mifd_consts.vh"

module mifd_decoder #(
	parameter CNT_W = 16
) (
	input wire clk_sys,
	input wire reset,
	input wire [`MIFD_WORD_W-1:0] instr_word,
	input wire cond_true,
	input wire [`MIFD_RA_W-1:0] reg_addr,
	input wire [`MIFD_RD_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [`MIFD_RD_W-1:0] reg_rdata,
	output reg [`MIFD_PH_W-1:0] q_phase,
	output reg cycle_start,
	output reg [1:0] instr_class,
	output reg [`MIFD_FADDR_W-1:0] file_addr,
	output reg dest_w_we,
	output reg dest_f_we,
	output reg [`MIFD_BSEL_W-1:0] bit_sel,
	output reg [7:0] bit_mask,
	output reg [`MIFD_LIT_W-1:0] literal,
	output reg lit_long,
	output reg pc_load,
	output reg skip_test,
	output reg idle_cycle
);

	// =====================================================
	// helper functions
	// group of a raw word; the control words share the 00 top code
	function [1:0] mifd_group;
		input [`MIFD_WORD_W-1:0] w;
		begin
			mifd_group = `MIFD_CLS_LITCTL; // see RQ2
			if (w[`MIFD_TOP_HI:`MIFD_TOP_LO] == `MIFD_TOP_BIT) begin
				mifd_group = `MIFD_CLS_BIT;
			end else if (w[`MIFD_TOP_HI:`MIFD_TOP_LO] == `MIFD_TOP_BYTE) begin
				if (w[`MIFD_OPS_HI:`MIFD_OPS_LO] != `MIFD_OPS_CTL || w[`MIFD_DEST_BIT]) begin
					mifd_group = `MIFD_CLS_BYTE;
				end
			end
		end
	endfunction

	function [7:0] mifd_onehot;
		input [`MIFD_BSEL_W-1:0] sel;
		begin
			mifd_onehot = 8'h01 << sel; // see RQ6
		end
	endfunction

	// =====================================================
	// phase divider
	wire [`MIFD_PH_W-1:0] phase;
	wire cycle_end;

	mifd_qphase #(
		.PERIODS(`MIFD_Q_PER_CYC)
	) u_qphase (
		.clk_sys(clk_sys),
		.reset(reset),
		.phase(phase),
		.cycle_end(cycle_end)
	);

	// =====================================================
	// control state
	reg run_en;
	reg clr_req;
	reg legacy_seen;
	reg [`MIFD_WORD_W-1:0] last_word;
	reg [CNT_W-1:0] cyc_count;
	reg [CNT_W-1:0] idle_count;

	// =====================================================
	// combinational field decode
	// only the bits that an instruction uses are looked at, so
	// don't-care positions never change the outcome
	reg [1:0] next_class;
	reg next_w_we;
	reg next_f_we;
	reg next_pc_load;
	reg next_skip;
	reg next_lit_long;
	reg [`MIFD_LIT_W-1:0] next_literal;
	reg next_legacy;
	reg next_flush;
	wire [1:0] top_code;
	wire [3:0] ops_code;
	wire dest_sel;

	assign top_code = instr_word[`MIFD_TOP_HI:`MIFD_TOP_LO]; // see RQ1
	assign ops_code = instr_word[`MIFD_OPS_HI:`MIFD_OPS_LO];
	assign dest_sel = instr_word[`MIFD_DEST_BIT]; // see RQ12

	always @* begin
		next_class = mifd_group(instr_word); // see RQ8
		next_w_we = 1'b0;
		next_f_we = 1'b0;
		next_pc_load = 1'b0;
		next_skip = 1'b0;
		next_lit_long = 1'b0;
		next_literal = {3'h0, instr_word[`MIFD_LIT8_HI:0]}; // see RQ7
		next_legacy = 1'b0;
		case (next_class)
			`MIFD_CLS_BYTE: begin
				next_w_we = ~dest_sel; // see RQ3
				next_f_we = dest_sel; // see RQ4
				next_skip = (ops_code == `MIFD_OPS_DECSKIP) ||
					(ops_code == `MIFD_OPS_INCSKIP);
			end
			`MIFD_CLS_BIT: begin
				// clear and set modify the file; the two tests only read it
				next_f_we = ~instr_word[`MIFD_BTEST_BIT];
				next_skip = instr_word[`MIFD_BTEST_BIT];
			end
			`MIFD_CLS_LITCTL: begin
				if (top_code == `MIFD_TOP_JUMP) begin
					next_pc_load = 1'b1;
					next_lit_long = 1'b1;
					next_literal = instr_word[`MIFD_LIT11_HI:0]; // see RQ7
				end else if (top_code == `MIFD_TOP_LIT) begin
					next_w_we = 1'b1;
					next_pc_load = (instr_word[`MIFD_LSEL_HI:`MIFD_LSEL_LO] ==
						`MIFD_LSEL_RETLIT);
				end else begin
					next_pc_load = (instr_word == `MIFD_W_RETURN) ||
						(instr_word == `MIFD_W_RETIRQ);
					// kept for visibility; the core still decodes them as control words that write nothing, not as idle slots
					next_legacy = (instr_word == `MIFD_W_OPTLOAD) ||
						((instr_word >= `MIFD_W_DIRLO) &&
						(instr_word <= `MIFD_W_DIRHI)); // see RQ11
				end
			end
			default: begin
				next_class = `MIFD_CLS_LITCTL;
			end
		endcase
	end

	// the cycle after a jump or a taken skip executes as idle
	always @* begin
		next_flush = pc_load | (skip_test & cond_true); // see RQ9
	end

	// =====================================================
	// decoded outputs, updated once per instruction cycle
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			instr_class <= `MIFD_CLS_IDLE;
			file_addr <= 7'h00;
			dest_w_we <= 1'b0;
			dest_f_we <= 1'b0;
			bit_sel <= 3'h0;
			bit_mask <= 8'h00;
			literal <= 11'h000;
			lit_long <= 1'b0;
			pc_load <= 1'b0;
			skip_test <= 1'b0;
			idle_cycle <= 1'b1;
			last_word <= 14'h0000;
		end else if (cycle_end) begin // see RQ10
			file_addr <= instr_word[`MIFD_FADDR_HI:`MIFD_FADDR_LO]; // see RQ5
			bit_sel <= instr_word[`MIFD_BSEL_HI:`MIFD_BSEL_LO];
			literal <= next_literal;
			lit_long <= next_lit_long;
			last_word <= instr_word;
			if (next_flush || !run_en) begin
				// forced idle: no writes, no branch, no test
				instr_class <= `MIFD_CLS_IDLE; // see RQ9
				dest_w_we <= 1'b0;
				dest_f_we <= 1'b0;
				bit_mask <= 8'h00;
				pc_load <= 1'b0;
				skip_test <= 1'b0;
				idle_cycle <= 1'b1;
			end else begin
				instr_class <= next_class;
				dest_w_we <= next_w_we;
				dest_f_we <= next_f_we;
				if (next_class == `MIFD_CLS_BIT) begin
					bit_mask <= mifd_onehot(instr_word[`MIFD_BSEL_HI:`MIFD_BSEL_LO]);
				end else begin
					bit_mask <= 8'h00;
				end
				pc_load <= next_pc_load;
				skip_test <= next_skip;
				idle_cycle <= 1'b0;
			end
		end
	end

	// =====================================================
	// cycle marker and phase copy
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cycle_start <= 1'b0;
			q_phase <= 2'h0;
		end else begin
			cycle_start <= cycle_end;
			q_phase <= phase;
		end
	end

	// =====================================================
	// cycle statistics
	// counters wrap silently; software samples them as it needs
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cyc_count <= {CNT_W{1'b0}};
			idle_count <= {CNT_W{1'b0}};
		end else if (clr_req) begin
			cyc_count <= {CNT_W{1'b0}};
			idle_count <= {CNT_W{1'b0}};
		end else if (cycle_start) begin
			cyc_count <= cyc_count + {{(CNT_W-1){1'b0}}, 1'b1};
			if (idle_cycle) begin
				idle_count <= idle_count + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// =====================================================
	// register writes
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			run_en <= `MIFD_CTRL_RST;
			clr_req <= 1'b0;
		end else begin
			clr_req <= 1'b0;
			if (reg_wr && reg_addr == `MIFD_RA_CTRL) begin
				run_en <= reg_wdata[`MIFD_CTRL_RUN];
				clr_req <= reg_wdata[`MIFD_CTRL_CLR];
			end
		end
	end

	// legacy flag: write one to clear; a new sighting beats the clear
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			legacy_seen <= 1'b0;
		end else if (cycle_end && next_legacy && !next_flush && run_en) begin
			legacy_seen <= 1'b1;
		end else if (reg_wr && reg_addr == `MIFD_RA_STAT &&
			reg_wdata[`MIFD_STAT_LEGACY]) begin
			legacy_seen <= 1'b0;
		end
	end

	// =====================================================
	// register reads, data valid the cycle after the strobe
	reg [`MIFD_RD_W-1:0] next_rdata;

	always @* begin
		next_rdata = 16'h0000;
		case (reg_addr)
			`MIFD_RA_CTRL: begin
				next_rdata = {15'h0000, run_en};
			end
			`MIFD_RA_WORD: begin
				next_rdata = {2'h0, last_word};
			end
			`MIFD_RA_STAT: begin
				next_rdata = {8'h00, legacy_seen, skip_test, pc_load, idle_cycle,
					dest_f_we, dest_w_we, instr_class};
			end
			`MIFD_RA_CYC: begin
				next_rdata = cyc_count[`MIFD_RD_W-1:0];
			end
			`MIFD_RA_IDLE: begin
				next_rdata = idle_count[`MIFD_RD_W-1:0];
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

endmodule
`default_nettype wire

//--- rtl/mifd_consts.vh
// constants of the instruction field decoder
//
// Overview of operation
// RQ1: each instruction is one 14-bit word
// RQ2: words sort into byte, bit, literal-control groups
// RQ3: byte op with select zero writes working register
// RQ4: byte op with select one writes file register
// RQ5: file operand addresses registers 0x00 to 0x7F
// RQ6: bit selector picks one of eight bits
// RQ7: literal is eight or eleven bits wide
// RQ8: don't-care positions ignored, zero recommended
// RQ9: skip or jump adds one idle cycle
// RQ10: instruction cycle is four oscillator periods
// RQ11: software avoids option and direction load
// RQ12: destination bit sits above file address
`ifndef MIFD_CONSTS_VH
`define MIFD_CONSTS_VH

// =====================================================
// word layout
`define MIFD_WORD_W 14
`define MIFD_TOP_HI 13
`define MIFD_TOP_LO 12
`define MIFD_OPS_HI 11
`define MIFD_OPS_LO 8
`define MIFD_DEST_BIT 7
`define MIFD_FADDR_HI 6
`define MIFD_FADDR_LO 0
`define MIFD_FADDR_W 7
`define MIFD_BSEL_HI 9
`define MIFD_BSEL_LO 7
`define MIFD_BSEL_W 3
`define MIFD_BTEST_BIT 11
`define MIFD_LIT8_HI 7
`define MIFD_LIT11_HI 10
`define MIFD_LIT_W 11
`define MIFD_LSEL_HI 11
`define MIFD_LSEL_LO 10

// =====================================================
// opcode codes
`define MIFD_TOP_BYTE 2'h0
`define MIFD_TOP_BIT 2'h1
`define MIFD_TOP_JUMP 2'h2
`define MIFD_TOP_LIT 2'h3
`define MIFD_OPS_CTL 4'h0
`define MIFD_OPS_DECSKIP 4'hB
`define MIFD_OPS_INCSKIP 4'hF
`define MIFD_LSEL_RETLIT 2'h1
`define MIFD_W_RETURN 14'h0008
`define MIFD_W_RETIRQ 14'h0009
`define MIFD_W_OPTLOAD 14'h0062
`define MIFD_W_DIRLO 14'h0065
`define MIFD_W_DIRHI 14'h0067

// =====================================================
// decoded classes
`define MIFD_CLS_BYTE 2'h0
`define MIFD_CLS_BIT 2'h1
`define MIFD_CLS_LITCTL 2'h2
`define MIFD_CLS_IDLE 2'h3

// =====================================================
// instruction cycle timing
`define MIFD_Q_PER_CYC 4
`define MIFD_PH_W 2
`define MIFD_PH_LAST 2'h3

// =====================================================
// software registers
`define MIFD_RA_W 4
`define MIFD_RD_W 16
`define MIFD_RA_CTRL 4'h0
`define MIFD_RA_WORD 4'h1
`define MIFD_RA_STAT 4'h2
`define MIFD_RA_CYC 4'h3
`define MIFD_RA_IDLE 4'h4
`define MIFD_CTRL_RST 1'h1
`define MIFD_CTRL_RUN 0
`define MIFD_CTRL_CLR 1
`define MIFD_STAT_LEGACY 7

`endif

//--- rtl/mifd_qphase.v
// four-phase divider that paces instruction cycles
`timescale 1ns/1ps
`default_nettype none
`include "mifd_consts.vh"

module mifd_qphase #(
	parameter PERIODS = `MIFD_Q_PER_CYC
) (
	input wire clk_sys,
	input wire reset,
	output reg [`MIFD_PH_W-1:0] phase,
	output reg cycle_end
);

	// =====================================================
	// phase counter
	// cycle_end marks the clock in which the last phase is held
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			phase <= 2'h0;
			cycle_end <= 1'b0;
		end else begin
			if (phase == PERIODS[`MIFD_PH_W-1:0] - 2'h1) begin // see RQ10
				phase <= 2'h0;
			end else begin
				phase <= phase + 2'h1;
			end
			cycle_end <= (phase == PERIODS[`MIFD_PH_W-1:0] - 2'h2);
		end
	end

endmodule
`default_nettype wire

//--- dv/mifd_prog_mem.sv
// program memory model feeding one word per instruction cycle
`timescale 1ns/1ps
`default_nettype none
module mifd_prog_mem (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic cycle_start,
	output logic [13:0] instr_word
);
	logic [3:0] ptr;
	// next word appears one clock after the load edge, stable long before the next one
	always @(posedge clk_sys or posedge reset) begin
		if (reset) ptr <= 4'h0;
		else if (cycle_start) ptr <= ptr + 4'h1;
	end
	// option and direction loads are kept out of the program
	always_comb begin
		case (ptr)
			4'h0: instr_word = 14'h0785;
			4'h1: instr_word = 14'h0705;
			4'h2: instr_word = 14'h1685;
			4'h3: instr_word = 14'h33FF;
			4'h4: instr_word = 14'h2ABC;
			4'h5: instr_word = 14'h0785;
			4'h6: instr_word = 14'h0B85;
			4'h7: instr_word = 14'h0705;
			4'h9: instr_word = 14'h1A05;
			4'hA: instr_word = 14'h0F05;
			4'hB: instr_word = 14'h3412;
			4'hC: instr_word = 14'h0785;
			4'hD: instr_word = 14'h0008;
			default: instr_word = 14'h0000;
		endcase
	end
endmodule
`default_nettype wire

//--- dv/mifd_decoder_sva.sv
// checker for the instruction field decoder
`timescale 1ns/1ps
`default_nettype none
module mifd_decoder_sva (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [13:0] instr_word,
	input wire logic cond_true,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [1:0] q_phase,
	input wire logic cycle_start,
	input wire logic [1:0] instr_class,
	input wire logic [6:0] file_addr,
	input wire logic dest_w_we,
	input wire logic dest_f_we,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] bit_mask,
	input wire logic [10:0] literal,
	input wire logic lit_long,
	input wire logic pc_load,
	input wire logic skip_test,
	input wire logic idle_cycle
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ====================
	// sequences
	sequence skip_hit_s;
		cycle_start && skip_test ##3 cond_true;
	endsequence
	sequence jump_s;
		cycle_start && pc_load;
	endsequence
	// ====================
	// assertions
	cyc_period_a: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
		else $error("instruction cycle not four clocks");
	phase_align_a: assert property (cycle_start |-> q_phase == 2'h3)
		else $error("phase copy not at last phase at cycle start");
	out_stand_a: assert property (!cycle_start |-> $stable({instr_class, file_addr, literal}))
		else $error("decode output moved inside a cycle");
	file_addr_a: assert property (cycle_start |-> file_addr == $past(instr_word[6:0]))
		else $error("file address field wrong");
	dest_sel_a: assert property (cycle_start && instr_class == 2'h0 |->
		dest_f_we == $past(instr_word[7]) && dest_w_we == !$past(instr_word[7]))
		else $error("destination select wrong");
	bit_mask_a: assert property (instr_class == 2'h1 |-> bit_mask == (8'h01 << bit_sel))
		else $error("bit mask not one-hot of selector");
	short_lit_a: assert property (cycle_start && !lit_long |->
		literal == {3'h0, $past(instr_word[7:0])})
		else $error("short literal wrong");
	long_lit_a: assert property (cycle_start && instr_class != 2'h3 &&
		$past(instr_word[13:12]) == 2'h2 |-> lit_long && pc_load &&
		literal == $past(instr_word[10:0]))
		else $error("jump literal wrong");
	jump_idle_a: assert property (jump_s |-> ##4 idle_cycle && instr_class == 2'h3)
		else $error("no idle slot after jump");
	skip_idle_a: assert property (skip_hit_s |=> idle_cycle && !dest_f_we && !dest_w_we)
		else $error("no idle slot after taken skip");
	rdata_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside its slot");
endmodule
bind mifd_decoder mifd_decoder_sva i_sva (.*);
`default_nettype wire

//--- dv/mifd_decoder_bench.sv
// self-checking bench for the instruction field decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin num_errors++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module mifd_decoder_bench;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic cond_true = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	wire [13:0] instr_word;
	wire [15:0] reg_rdata;
	wire [1:0] q_phase, instr_class;
	wire [6:0] file_addr;
	wire [2:0] bit_sel;
	wire [7:0] bit_mask;
	wire [10:0] literal;
	wire cycle_start, dest_w_we, dest_f_we, lit_long, pc_load, skip_test, idle_cycle;
	int num_errors = 0;
	int comparisons = 0;
	logic [15:0] rv;
	// {idle, skip, pc_load, f_we, w_we, class} per slot of the program
	logic [6:0] exp_tab [0:14] = '{7'h08, 7'h04, 7'h09, 7'h06, 7'h12, 7'h43, 7'h28, 7'h43, 7'h02,
		7'h21, 7'h24, 7'h16, 7'h43, 7'h12, 7'h43};
	// {lit_long, literal} per slot
	logic [11:0] exp_lit [0:14] = '{12'h085, 12'h005, 12'h085, 12'h0FF, 12'hABC, 12'h085,
		12'h085, 12'h005, 12'h000, 12'h005, 12'h005, 12'h012, 12'h085, 12'h008, 12'h000};
	logic [7:0] exp_mask [0:14] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// test outcome seen at the next slot; the two skips in slots 9 and 10 fail
	logic [14:0] cond_tab = 15'h79FF;
	always #25 clk_sys = ~clk_sys;
	mifd_decoder i_dut (.clk_sys(clk_sys), .reset(reset), .instr_word(instr_word),
		.cond_true(cond_true), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .q_phase(q_phase), .cycle_start(cycle_start),
		.instr_class(instr_class), .file_addr(file_addr), .dest_w_we(dest_w_we),
		.dest_f_we(dest_f_we), .bit_sel(bit_sel), .bit_mask(bit_mask), .literal(literal),
		.lit_long(lit_long), .pc_load(pc_load), .skip_test(skip_test), .idle_cycle(idle_cycle));
	mifd_prog_mem i_mem (.clk_sys(clk_sys), .reset(reset), .cycle_start(cycle_start),
		.instr_word(instr_word));
	task stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// settle after the edge so the flag is read after its update lands
	task wait_cs;
		int n;
		n = 0;
		@(posedge clk_sys);
		#1;
		while (cycle_start !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n == 20) begin
			num_errors++;
			stop_test;
		end
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 0; i < 15; i++) begin
			wait_cs;
			`CHK("slot flags", exp_tab[i], {idle_cycle, skip_test, pc_load, dest_f_we, dest_w_we, instr_class})
			`CHK("literal", exp_lit[i], {lit_long, literal})
			`CHK("bit mask", exp_mask[i], bit_mask)
			@(posedge clk_sys);
			cond_true <= cond_tab[i];
		end
		rd(4'h3, rv);
		`CHK("cycle count", 16'h000F, rv)
		rd(4'h4, rv);
		`CHK("idle count", 16'h0004, rv)
		$display("program test done");
		wr(4'h0, 16'h0000);
		wait_cs;
		wait_cs;
		`CHK("stopped class", 2'h3, instr_class)
		rd(4'h0, rv);
		`CHK("ctrl", 16'h0000, rv)
		rd(4'h2, rv);
		`CHK("status", 16'h0013, rv)
		rd(4'hF, rv);
		`CHK("unmapped", 16'h0000, rv)
		wr(4'h0, 16'h0002);
		wait_cs;
		rd(4'h3, rv);
		`CHK("cleared cycles", 16'h0001, rv)
		rd(4'h4, rv);
		`CHK("cleared idle", 16'h0001, rv)
		wr(4'h0, 16'h0001);
		rd(4'h0, rv);
		`CHK("ctrl run", 16'h0001, rv)
		$display("register test done");
		stop_test;
	end
endmodule
`default_nettype wire
